// file: logic/usart_bit_tick.sv
/*
  Bit tick generator: divisor down-counter with a bit-phase prescaler, or
  edges of the synchronised transfer clock in synchronous slave mode.
  Assumes the transfer clock input is already synchronised.
*/
`timescale 1ns/1ps

module usart_bit_tick
  import usart_tx_pkg::*;
#(
  parameter int DIV_W = `DIVISOR_W
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_b,
  input  wire logic             i_run,
  input  wire logic [DIV_W-1:0] i_divisor,
  input  wire logic             i_double,
  input  wire logic             i_sync_mode,
  input  wire logic             i_ext_clk,
  input  wire logic             i_xck_sync,
  input  wire logic             i_clk_pol,
  output logic                  o_tick,
  output logic                  o_xck
);

  typedef struct packed {
    logic [DIV_W-1:0] down;
    logic [4:0]       phase;
    logic             xck_d;
    logic             xck;
    logic             tick;
  } tick_s;

  tick_s s_reg;
  tick_s s_next;
  logic [4:0] ratio;

  always_comb begin
    ratio  = i_sync_mode ? `DIV_SYNC : (i_double ? `DIV_DOUBLE : `DIV_NORMAL);
    s_next = s_reg;
    s_next.tick  = 1'b0;
    s_next.xck_d = i_xck_sync;
    if (!i_run) begin
      s_next.down  = i_divisor;
      s_next.phase = 5'h0_0;
      s_next.xck   = i_clk_pol;
    end else if (i_sync_mode && i_ext_clk) begin
      // Data changes on the edge opposite to the sampling edge
      s_next.tick = (i_xck_sync != s_reg.xck_d) && (i_xck_sync == ~i_clk_pol);
    end else if (s_reg.down == '0) begin
      s_next.down = i_divisor;
      // A phase left over from a larger ratio must not wrap through all 32 steps
      if (s_reg.phase >= ratio - 5'h0_1) begin
        s_next.phase = 5'h0_0;
        s_next.tick  = 1'b1;
      end else begin
        s_next.phase = s_reg.phase + 5'h0_1;
      end
      if (i_sync_mode && (s_reg.phase == 5'h0_0 || s_reg.phase == 5'h0_1)) begin
        s_next.xck = (s_reg.phase == 5'h0_0) ? ~i_clk_pol : i_clk_pol;
      end
    end else begin
      s_next.down = s_reg.down - {{(DIV_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      s_reg <= '{down: '0, phase: 5'h0_0, xck_d: 1'b1, xck: 1'b0, tick: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_tick = s_reg.tick;
  assign o_xck  = s_reg.xck;

endmodule // usart_bit_tick

// file: logic/usart_sync2.sv
/*
  Two flip-flop synchroniser for a level from outside the clock domain.
  Assumes a single clock and a synchronous active low reset.
*/
`timescale 1ns/1ps

module usart_sync2 #(
  parameter logic RESET_VAL = 1'b1
) (
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  input  wire logic i_async,
  output logic      o_sync
);

  logic meta_reg;
  logic sync_reg;

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      meta_reg <= RESET_VAL;
      sync_reg <= RESET_VAL;
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;

endmodule // usart_sync2

// file: logic/usart_tx.sv
/*
  Serial frame transmitter: single-entry transmit buffer, shift sequencer,
  parity generation, transmit and ready/complete flags, pin override.
  Assumes configuration ports are steady during traffic and that the
  transfer clock pin and receive flags come from outside the clock domain.
*/
`timescale 1ns/1ps

module usart_tx
  import usart_tx_pkg::*;
#(
  parameter int DIV_W = `DIVISOR_W
) (
  input  wire logic                     I_CORE_CLK,
  input  wire logic                     I_RST_B,
  input  wire logic                     I_TX_ENABLE_BIT,
  input  wire logic                     I_RX_ENABLE_BIT,
  input  wire logic [7:0]               I_DATA_IO_WDATA,
  input  wire logic                     I_DATA_IO_WRITE,
  input  wire logic                     I_TX_NINTH_BIT,
  input  wire usart_tx_pkg::char_size_t I_CHAR_SIZE_FIELD,
  input  wire usart_tx_pkg::parity_mode_t I_PARITY_MODE_FIELD,
  input  wire logic                     I_STOP_BIT_SELECT,
  input  wire logic [DIV_W-1:0]         I_BAUD_DIVISOR,
  input  wire logic                     I_DOUBLE_SPEED_BIT,
  input  wire logic                     I_SYNC_MODE,
  input  wire logic                     I_SYNC_EXT_CLK,
  input  wire logic                     I_CLK_POLARITY,
  input  wire logic                     I_TRANSFER_CLOCK_PIN_IN,
  input  wire logic                     I_TX_COMPLETE_CLEAR,
  input  wire logic                     I_TX_COMPLETE_IRQ_ACK,
  input  wire logic                     I_TX_BUFFER_EMPTY_IRQ_ENABLE,
  input  wire logic                     I_RX_UNREAD,
  input  wire logic                     I_GPIO_TX_OUT,
  input  wire logic                     I_GPIO_TX_OE_B,
  output logic                          O_SERIAL_TX_PIN_OUT,
  output logic                          O_SERIAL_TX_PIN_OE_B,
  output logic                          O_TRANSFER_CLOCK_PIN_OUT,
  output logic                          O_TRANSFER_CLOCK_PIN_OE_B,
  output logic                          O_TX_BUFFER_EMPTY_FLAG,
  output logic                          O_TX_BUFFER_EMPTY_IRQ,
  output logic                          O_TX_COMPLETE_FLAG,
  output logic                          O_RX_COMPLETE_FLAG,
  output logic                          O_TX_ACTIVE
);

  import usart_tx_pkg::*;

  typedef struct packed {
    tx_state_e state;
    char_t     buf_data;
    logic      buf_full;
    char_t     shift;
    bit_cnt_t  bit_cnt;
    logic      parity;
    logic      stop2;
    logic      has_parity;
    logic      tx_out;
    logic      tx_oe_b;
    logic      xck_out;
    logic      xck_oe_b;
    logic      empty_flag;
    logic      empty_irq;
    logic      complete_flag;
    logic      rx_flag;
    logic      active;
  } tx_s;

  tx_s s_reg;
  tx_s s_next;

  logic     tick;
  logic     xck_gen;
  logic     xck_sync;
  logic     rx_unread_sync;
  logic     owns_pin;
  logic     frame_done;
  logic     load_now;
  logic     data_last;
  bit_cnt_t n_bits;
  char_t    masked;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers and bit timing

  usart_sync2 #(
    .RESET_VAL (1'b1)
  ) u_sync_xck (
    .i_clk   (I_CORE_CLK),
    .i_rst_b (I_RST_B),
    .i_async (I_TRANSFER_CLOCK_PIN_IN),
    .o_sync  (xck_sync)
  );

  usart_sync2 #(
    .RESET_VAL (1'b0)
  ) u_sync_rx (
    .i_clk   (I_CORE_CLK),
    .i_rst_b (I_RST_B),
    .i_async (I_RX_UNREAD),
    .o_sync  (rx_unread_sync)
  );

  usart_bit_tick #(
    .DIV_W (DIV_W)
  ) u_tick (
    .i_clk       (I_CORE_CLK),
    .i_rst_b     (I_RST_B),
    .i_run       (owns_pin),
    .i_divisor   (I_BAUD_DIVISOR),
    .i_double    (I_DOUBLE_SPEED_BIT),
    .i_sync_mode (I_SYNC_MODE),
    .i_ext_clk   (I_SYNC_EXT_CLK),
    .i_xck_sync  (xck_sync),
    .i_clk_pol   (I_CLK_POLARITY),
    .o_tick      (tick),
    .o_xck       (xck_gen)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Frame format decode

  always_comb begin
    // Size field 0..3 gives 5..8 bits, 7 gives 9
    if (I_CHAR_SIZE_FIELD == `CHAR_SIZE_NINE) begin
      n_bits = 4'h9;
    end else begin
      n_bits = 4'h5 + {2'b00, I_CHAR_SIZE_FIELD[1:0]};
    end
    masked = {I_TX_NINTH_BIT, I_DATA_IO_WDATA};
    for (int i = 0; i < `DATA_W; i++) begin
      if (i >= int'(n_bits)) begin
        masked[i] = 1'b0;
      end
    end
  end

  assign owns_pin   = (s_reg.state != ST_OFF);
  assign data_last  = (s_reg.bit_cnt == n_bits - 4'h1);
  assign frame_done = tick && (s_reg.state == ST_STOP) && !s_reg.stop2;
  assign load_now   = s_reg.buf_full && ((s_reg.state == ST_IDLE && tick) || frame_done);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer and flags

  always_comb begin
    s_next = s_reg;
    s_next.rx_flag = rx_unread_sync;

    case (s_reg.state)
      ST_OFF: begin
        if (I_TX_ENABLE_BIT) begin
          s_next.state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (!I_TX_ENABLE_BIT && !s_reg.buf_full) begin
          s_next.state = ST_OFF;
        end
      end
      ST_START: begin
        if (tick) begin
          s_next.state   = ST_DATA;
          s_next.bit_cnt = '0;
          s_next.tx_out  = s_reg.shift[0];
          s_next.shift   = {1'b0, s_reg.shift[`DATA_W-1:1]};
        end
      end
      ST_DATA: begin
        if (tick) begin
          if (!data_last) begin
            s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
            s_next.tx_out  = s_reg.shift[0];
            s_next.shift   = {1'b0, s_reg.shift[`DATA_W-1:1]};
          end else if (s_reg.has_parity) begin
            s_next.state  = ST_PARITY;
            s_next.tx_out = s_reg.parity;
          end else begin
            s_next.state  = ST_STOP;
            s_next.tx_out = 1'b1;
          end
        end
      end
      ST_PARITY: begin
        if (tick) begin
          s_next.state  = ST_STOP;
          s_next.tx_out = 1'b1;
        end
      end
      ST_STOP: begin
        if (tick) begin
          if (s_reg.stop2) begin
            s_next.stop2 = 1'b0;
          end else begin
            s_next.state = ST_IDLE;
            s_next.tx_out = 1'b1;
            if (!s_reg.buf_full) begin
              s_next.complete_flag = 1'b1;
            end
          end
        end
      end
      default: begin
        s_next.state = ST_OFF;
      end
    endcase

    // Software clear skipped on a completion in the same cycle, so the completion wins
    if ((I_TX_COMPLETE_CLEAR || I_TX_COMPLETE_IRQ_ACK) && !(frame_done && !s_reg.buf_full)) begin
      s_next.complete_flag = 1'b0;
    end

    if (load_now) begin
      s_next.state      = ST_START;
      s_next.tx_out     = 1'b0;
      s_next.shift      = s_reg.buf_data;
      s_next.parity     = (^s_reg.buf_data) ^ I_PARITY_MODE_FIELD[`PARITY_ODD_BIT];
      s_next.has_parity = I_PARITY_MODE_FIELD[`PARITY_EN_BIT];
      s_next.stop2      = I_STOP_BIT_SELECT;
      s_next.buf_full   = 1'b0;
    end

    if (I_DATA_IO_WRITE && (!s_reg.buf_full || load_now)) begin
      s_next.buf_data = masked;
      s_next.buf_full = 1'b1;
    end

    if (s_next.state == ST_OFF) begin
      s_next.tx_out  = I_GPIO_TX_OUT;
      s_next.tx_oe_b = I_GPIO_TX_OE_B;
    end else begin
      s_next.tx_oe_b = 1'b0;
      if (s_next.state == ST_IDLE) begin
        s_next.tx_out = 1'b1;
      end
    end

    s_next.xck_oe_b   = !(owns_pin && I_SYNC_MODE && !I_SYNC_EXT_CLK);
    s_next.xck_out    = xck_gen;
    s_next.empty_flag = !s_next.buf_full;
    s_next.empty_irq  = !s_next.buf_full && I_TX_BUFFER_EMPTY_IRQ_ENABLE;
    s_next.active     = (s_next.state != ST_OFF) && (s_next.state != ST_IDLE);
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_B) begin
      s_reg <= '{state: ST_OFF, buf_data: '0, buf_full: 1'b0, shift: '0, bit_cnt: '0,
                 parity: 1'b0, stop2: 1'b0, has_parity: 1'b0, tx_out: 1'b1, tx_oe_b: 1'b1,
                 xck_out: 1'b0, xck_oe_b: 1'b1, empty_flag: 1'b1, empty_irq: 1'b0,
                 complete_flag: 1'b0, rx_flag: 1'b0, active: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign O_SERIAL_TX_PIN_OUT       = s_reg.tx_out;
  assign O_SERIAL_TX_PIN_OE_B      = s_reg.tx_oe_b;
  assign O_TRANSFER_CLOCK_PIN_OUT  = s_reg.xck_out;
  assign O_TRANSFER_CLOCK_PIN_OE_B = s_reg.xck_oe_b;
  assign O_TX_BUFFER_EMPTY_FLAG    = s_reg.empty_flag;
  assign O_TX_BUFFER_EMPTY_IRQ     = s_reg.empty_irq;
  assign O_TX_COMPLETE_FLAG        = s_reg.complete_flag;
  assign O_RX_COMPLETE_FLAG        = s_reg.rx_flag;
  assign O_TX_ACTIVE               = s_reg.active;

endmodule // usart_tx

// file: logic/usart_tx_cfg.svh
/*
  Constants for the serial frame transmitter: field encodings, sizes and timing counts.
  Assumes inclusion by bare name from the package; design modules rely on its macros without including it.
*/
// Notes on behaviour
// - All thirty frame formats are supported
// - Start bit, then data bits LSB first
// - Parity bit follows last data bit
// - Next frame back to back, else idle
// - Idle line level is high
// - Format from size, parity, stop fields
// - One shared format for both directions
// - Receiver checks only the first stop bit
// - Parity is XOR of data, odd inverts
// - Transmit enable takes over the pin
// - Synchronous mode uses transfer clock pin
// - Data write loads buffer, starts sending
// - Shifter reloads when idle or after stop
// - Bit rate from divisor or transfer clock
// - Unused upper data bits are ignored
// - Size seven takes ninth bit from flag
// - Empty flag set when shifter takes buffer
// - Receive complete shows unread receive data
// - Complete flag sets after last frame
// - Data write clears empty flag
// - Parity enabled by upper mode bit
// - Disable waits until nothing is pending
`ifndef USART_TX_CFG_SVH
`define USART_TX_CFG_SVH

`define CHAR_SIZE_W        3
`define CHAR_SIZE_NINE     3'h7
`define PARITY_MODE_W      2
`define PARITY_EN_BIT      1
`define PARITY_ODD_BIT     0
`define DIVISOR_W          12
`define DIV_NORMAL         5'h10
`define DIV_DOUBLE         5'h08
`define DIV_SYNC           5'h02
`define BIT_CNT_W          4
`define DATA_W             9

`endif

// file: logic/usart_tx_pkg.sv
/*
  Types for the serial frame transmitter.
  Assumes the constants header is on the include path.
*/
`include "usart_tx_cfg.svh"

package usart_tx_pkg;

  typedef logic [`CHAR_SIZE_W-1:0]   char_size_t;
  typedef logic [`PARITY_MODE_W-1:0] parity_mode_t;
  typedef logic [`DIVISOR_W-1:0]     divisor_t;
  typedef logic [`DATA_W-1:0]        char_t;
  typedef logic [`BIT_CNT_W-1:0]     bit_cnt_t;

  typedef enum logic [5:0] {
    ST_OFF    = 6'b00_0001,
    ST_IDLE   = 6'b00_0010,
    ST_START  = 6'b00_0100,
    ST_DATA   = 6'b00_1000,
    ST_PARITY = 6'b01_0000,
    ST_STOP   = 6'b10_0000
  } tx_state_e;

endpackage

// file: tb/tb_usart_tx.sv
/*
  Testbench for the serial frame transmitter.
  Assumes the peer model samples the line at the bit length set here.
*/
`timescale 1ns/1ps

module tb_usart_tx;
  import usart_tx_pkg::*;
  logic         clk = 0, rst_b = 0, en = 0, wr = 0, b8 = 0, two = 0, dbl = 0, sync = 0;
  logic         clr = 0, ack = 0, irq_en = 0, unread = 0, gout = 0;
  logic [7:0]   wdata = '0, bit_len = 8'h10;
  logic [11:0]  div = 12'h000;
  char_size_t   size = '0;
  parity_mode_t par = '0;
  logic [3:0]   nbits = 4'h0;
  logic [12:0]  frame, e0, e1;
  logic [15:0]  frames, base;
  logic         tx_out, tx_oe_b, xck_oe_b, empty, irq, done, rxc, active, line;
  int           err_total = 0, checked = 0;
  char_size_t   sizes [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
  parity_mode_t pars [3] = '{2'h0, 2'h2, 2'h3};

  usart_tx usart_tx_i (
    .I_CORE_CLK(clk), .I_RST_B(rst_b), .I_TX_ENABLE_BIT(en), .I_RX_ENABLE_BIT(1'b0),
    .I_DATA_IO_WDATA(wdata), .I_DATA_IO_WRITE(wr), .I_TX_NINTH_BIT(b8), .I_CHAR_SIZE_FIELD(size),
    .I_PARITY_MODE_FIELD(par), .I_STOP_BIT_SELECT(two), .I_BAUD_DIVISOR(div), .I_DOUBLE_SPEED_BIT(dbl),
    .I_SYNC_MODE(sync), .I_SYNC_EXT_CLK(1'b0), .I_CLK_POLARITY(1'b0), .I_TRANSFER_CLOCK_PIN_IN(1'b0),
    .I_TX_COMPLETE_CLEAR(clr), .I_TX_COMPLETE_IRQ_ACK(ack), .I_TX_BUFFER_EMPTY_IRQ_ENABLE(irq_en),
    .I_RX_UNREAD(unread), .I_GPIO_TX_OUT(gout), .I_GPIO_TX_OE_B(1'b1), .O_SERIAL_TX_PIN_OUT(tx_out),
    .O_SERIAL_TX_PIN_OE_B(tx_oe_b), .O_TRANSFER_CLOCK_PIN_OUT(), .O_TRANSFER_CLOCK_PIN_OE_B(xck_oe_b),
    .O_TX_BUFFER_EMPTY_FLAG(empty), .O_TX_BUFFER_EMPTY_IRQ(irq), .O_TX_COMPLETE_FLAG(done),
    .O_RX_COMPLETE_FLAG(rxc), .O_TX_ACTIVE(active));

  usart_peer_model usart_peer_model_i (
    .i_clk(clk), .i_line(line), .i_bit_len(bit_len), .i_nbits(nbits), .o_frame(frame), .o_count(frames));

  // Released line is pulled up
  assign line = tx_oe_b ? 1'b1 : tx_out;

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkb(input logic g, input logic e);
    chk({15'h0000, g}, {15'h0000, e});
  endtask

  task automatic give_verdict;
    if (err_total == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic put(input logic [8:0] d);
    int n;
    n = 0;
    @(posedge clk);
    while (empty !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    wdata <= d[7:0];
    b8    <= d[8];
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic wait_frame(input logic [15:0] want, input logic [12:0] exp);
    int n;
    n = 0;
    while (frames < want && n < 600) begin
      @(posedge clk);
      n++;
    end
    chk({3'h0, frame}, {3'h0, exp});
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    while ((active !== 1'b0 || empty !== 1'b1) && n < 600) begin
      @(posedge clk);
      n++;
    end
  endtask

  // Expected line bits in sending order, start bit first
  function automatic logic [12:0] build(input logic [8:0] d, output logic [3:0] n);
    int          w;
    logic [12:0] f;
    w = (size == 3'h7) ? 9 : 5 + int'(size[1:0]);
    f = 13'h1FFF;
    f[0] = 1'b0;
    for (int i = 0; i < w; i++) f[i+1] = d[i];
    if (par[1]) f[w+1] = ^(d & ((9'h001 << w) - 9'h001)) ^ par[0];
    n = 4'(w + 2 + int'(par[1]) + int'(two));
    return f;
  endfunction

  task automatic frame_test(input logic [8:0] d, input char_size_t s, input parity_mode_t p,
                            input logic t, input logic drop);
    logic [3:0]  n;
    size <= s;
    par  <= p;
    two  <= t;
    clr  <= 1'b1;
    @(posedge clk);
    clr  <= 1'b0;
    e0 = build(d, n);
    nbits <= n;
    base = frames;
    put(d);
    if (drop) begin
      en <= 1'b0;
      repeat (2) @(posedge clk);
      chkb(tx_oe_b, 1'b0);
    end
    wait_frame(base + 16'h0001, e0);
    wait_idle();
    chkb(done, 1'b1);
    if (drop) begin
      repeat (3) @(posedge clk);
      chkb(tx_oe_b, 1'b1);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial forever #4 clk = ~clk;

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    give_verdict();
  end

  initial begin
    logic [3:0] n;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chkb(tx_oe_b, 1'b1);
    chkb(empty, 1'b1);
    en <= 1'b1;
    repeat (2) @(posedge clk);
    chkb(tx_oe_b, 1'b0);
    chkb(tx_out, 1'b1);
    for (int k = 0; k < 30; k++) frame_test(9'h1A5 ^ 9'(k * 37), sizes[k / 6], pars[(k / 2) % 3], 1'(k % 2), 1'b0);
    // Two frames back to back, then a write into a full buffer
    size <= 3'h3;
    par  <= 2'h0;
    two  <= 1'b0;
    nbits <= 4'hA;
    @(posedge clk);
    e0 = build(9'h0C3, n);
    e1 = build(9'h03C, n);
    base = frames;
    put(9'h0C3);
    put(9'h03C);
    @(posedge clk);
    chkb(empty, 1'b0);
    wdata <= 8'hFF;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    wait_frame(base + 16'h0001, e0);
    wait_frame(base + 16'h0002, e1);
    wait_idle();
    repeat (40) @(posedge clk);
    chk(frames, base + 16'h0002);
    chkb(done, 1'b1);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    @(posedge clk);
    chkb(done, 1'b0);
    irq_en <= 1'b1;
    repeat (3) @(posedge clk);
    chkb(irq, 1'b1);
    irq_en <= 1'b0;
    repeat (3) @(posedge clk);
    chkb(irq, 1'b0);
    unread <= 1'b1;
    repeat (5) @(posedge clk);
    chkb(rxc, 1'b1);
    unread <= 1'b0;
    repeat (5) @(posedge clk);
    chkb(rxc, 1'b0);
    dbl <= 1'b1;
    bit_len <= 8'h08;
    frame_test(9'h05A, 3'h3, 2'h3, 1'b0, 1'b0);
    dbl <= 1'b0;
    sync <= 1'b1;
    bit_len <= 8'h02;
    repeat (2) @(posedge clk);
    chkb(xck_oe_b, 1'b0);
    frame_test(9'h1C7, 3'h7, 2'h2, 1'b1, 1'b0);
    sync <= 1'b0;
    bit_len <= 8'h10;
    frame_test(9'h0F0, 3'h2, 2'h2, 1'b1, 1'b1);
    give_verdict();
  end
endmodule // tb_usart_tx

// file: tb/usart_peer_model.sv
/*
  Remote serial receiver on the transmit line.
  Assumes a pulled-up line and a bit length given in core clocks.
*/
`timescale 1ns/1ps

module usart_peer_model (
  input  wire logic        i_clk,
  input  wire logic        i_line,
  input  wire logic [7:0]  i_bit_len,
  input  wire logic [3:0]  i_nbits,
  output logic      [12:0] o_frame,
  output logic      [15:0] o_count
);
  logic [12:0] bits;

  initial begin
    o_frame = '1;
    o_count = '0;
    forever begin
      // Start bit is the first fall from the high idle line
      @(negedge i_line);
      bits = '1;
      repeat (i_bit_len / 8'h02) @(posedge i_clk);
      // One sample mid-bit, same format as the sender
      for (int i = 0; i < int'(i_nbits); i++) begin
        bits[i] = i_line;
        if (i + 1 < int'(i_nbits)) repeat (i_bit_len) @(posedge i_clk);
      end
      o_frame = bits;
      o_count = o_count + 16'h0001;
    end
  end
endmodule // usart_peer_model

// file: tb/usart_tx_properties.sv
/*
  Port checker for the serial frame transmitter.
  Assumes a divisor of zero, so one bit lasts at most sixteen clocks.
*/
`timescale 1ns/1ps

module usart_tx_properties (
  input wire logic I_CORE_CLK,
  input wire logic I_RST_B,
  input wire logic I_TX_ENABLE_BIT,
  input wire logic I_DATA_IO_WRITE,
  input wire logic I_TX_COMPLETE_CLEAR,
  input wire logic I_TX_COMPLETE_IRQ_ACK,
  input wire logic I_TX_BUFFER_EMPTY_IRQ_ENABLE,
  input wire logic I_RX_UNREAD,
  input wire logic O_SERIAL_TX_PIN_OUT,
  input wire logic O_SERIAL_TX_PIN_OE_B,
  input wire logic O_TX_BUFFER_EMPTY_FLAG,
  input wire logic O_TX_BUFFER_EMPTY_IRQ,
  input wire logic O_TX_COMPLETE_FLAG,
  input wire logic O_RX_COMPLETE_FLAG,
  input wire logic O_TX_ACTIVE
);
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_B);

  sequence s_frame_end;
    $fell(O_TX_ACTIVE);
  endsequence
  sequence s_unread_held;
    I_RX_UNREAD [*4];
  endsequence

  a_start_bit_low: assert property ($rose(O_TX_ACTIVE) |-> !O_SERIAL_TX_PIN_OUT)
    else $error("frame opened without a low start bit");
  a_stop_bit_high: assert property (s_frame_end |-> $past(O_SERIAL_TX_PIN_OUT))
    else $error("frame ended without a high stop bit");
  a_complete_on_end: assert property (s_frame_end |-> O_TX_COMPLETE_FLAG)
    else $error("complete flag missing after last frame");
  a_complete_cause: assert property ($rose(O_TX_COMPLETE_FLAG) |-> $fell(O_TX_ACTIVE) && O_TX_BUFFER_EMPTY_FLAG)
    else $error("complete flag set without a finished frame");
  a_complete_clear: assert property ((I_TX_COMPLETE_CLEAR || I_TX_COMPLETE_IRQ_ACK) && !O_TX_ACTIVE
                                     |=> !O_TX_COMPLETE_FLAG)
    else $error("complete flag not cleared");
  a_write_fills: assert property (I_DATA_IO_WRITE && O_TX_BUFFER_EMPTY_FLAG |=> !O_TX_BUFFER_EMPTY_FLAG)
    else $error("write left the empty flag set");
  a_buffer_drains: assert property (!O_TX_BUFFER_EMPTY_FLAG && !O_TX_ACTIVE |-> ##[1:18] O_TX_BUFFER_EMPTY_FLAG)
    else $error("idle shifter did not take the buffer");
  a_irq_follows: assert property ((O_TX_BUFFER_EMPTY_FLAG && I_TX_BUFFER_EMPTY_IRQ_ENABLE) [*2]
                                  |-> O_TX_BUFFER_EMPTY_IRQ)
    else $error("empty request missing");
  a_irq_masked: assert property (!I_TX_BUFFER_EMPTY_IRQ_ENABLE [*2] |-> !O_TX_BUFFER_EMPTY_IRQ)
    else $error("empty request while disabled");
  a_pin_taken: assert property (I_TX_ENABLE_BIT && O_SERIAL_TX_PIN_OE_B
                                |=> !O_SERIAL_TX_PIN_OE_B && O_SERIAL_TX_PIN_OUT)
    else $error("enable did not take the pin high");
  a_disable_waits: assert property (!I_TX_ENABLE_BIT && !O_SERIAL_TX_PIN_OE_B && !O_TX_BUFFER_EMPTY_FLAG
                                    |=> !O_SERIAL_TX_PIN_OE_B)
    else $error("pin released with data pending");
  a_rx_flag: assert property (s_unread_held |-> O_RX_COMPLETE_FLAG)
    else $error("receive flag missing");
endmodule // usart_tx_properties

bind usart_tx usart_tx_properties usart_tx_properties_i (
  .I_CORE_CLK(I_CORE_CLK), .I_RST_B(I_RST_B), .I_TX_ENABLE_BIT(I_TX_ENABLE_BIT),
  .I_DATA_IO_WRITE(I_DATA_IO_WRITE), .I_TX_COMPLETE_CLEAR(I_TX_COMPLETE_CLEAR),
  .I_TX_COMPLETE_IRQ_ACK(I_TX_COMPLETE_IRQ_ACK), .I_TX_BUFFER_EMPTY_IRQ_ENABLE(I_TX_BUFFER_EMPTY_IRQ_ENABLE),
  .I_RX_UNREAD(I_RX_UNREAD), .O_SERIAL_TX_PIN_OUT(O_SERIAL_TX_PIN_OUT),
  .O_SERIAL_TX_PIN_OE_B(O_SERIAL_TX_PIN_OE_B), .O_TX_BUFFER_EMPTY_FLAG(O_TX_BUFFER_EMPTY_FLAG),
  .O_TX_BUFFER_EMPTY_IRQ(O_TX_BUFFER_EMPTY_IRQ), .O_TX_COMPLETE_FLAG(O_TX_COMPLETE_FLAG),
  .O_RX_COMPLETE_FLAG(O_RX_COMPLETE_FLAG), .O_TX_ACTIVE(O_TX_ACTIVE)
);
